// ### cap_conv_pkg.sv
`default_nettype none
package cap_conv_pkg;
  // ----------------------------------------
  // Clock and channel count
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int NUM_CH  = 4;

  // ----------------------------------------
  // Register pointer values
  // ----------------------------------------
  localparam logic [7:0] PTR_RST        = 8'h00;
  localparam logic [7:0] ADDR_CONF      = 8'h0C;
  localparam logic [7:0] ADDR_OFF_FIRST = 8'h0D;
  localparam logic [7:0] ADDR_OFF_LAST  = 8'h10;
  localparam logic [7:0] ADDR_GAIN_FIRST = 8'h11;
  localparam logic [7:0] ADDR_GAIN_LAST = 8'h14;
  localparam logic [7:0] ADDR_MAKER     = 8'hFE;
  localparam logic [7:0] ADDR_PART      = 8'hFF;

  // ----------------------------------------
  // Configuration word layout
  // ----------------------------------------
  localparam int RST_BIT  = 15;
  localparam int RATE_HI  = 11;
  localparam int RATE_LO  = 10;
  localparam int RPT_BIT  = 8;
  localparam int START_HI = 7;
  localparam int DONE_HI  = 3;
  localparam logic [15:0] RSVD_MASK = 16'h7200;
  localparam logic [1:0]  RATE_RSVD = 2'h0;
  localparam logic [1:0]  RATE_100  = 2'h1;
  localparam logic [1:0]  RATE_200  = 2'h2;

  // ----------------------------------------
  // Reset values and trim formats
  // ----------------------------------------
  localparam logic [1:0]  RATE_RST = 2'h0;
  localparam logic [15:0] OFF_RST  = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'h4000;
  localparam int GAIN_FRAC = 14;
  localparam int OFF_FRAC  = 11;
  localparam int RES_FRAC  = 19;
  localparam int OFF_SHIFT = RES_FRAC - OFF_FRAC;

  // Arbitrary identity values
  localparam logic [15:0] MAKER_ID_DEF = 16'hA55A;
  localparam logic [15:0] PART_ID_DEF  = 16'h0C4D;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SRST_NS  = 1000;
  localparam int SRST_CYC = (SRST_NS * CLK_MHZ + 999) / 1000;
  localparam int SRST_W   = 8;
  localparam int PER_100_US = 10000;
  localparam int PER_200_US = 5000;
  localparam int PER_400_US = 2500;
  localparam int CYC_100 = PER_100_US * CLK_MHZ;
  localparam int CYC_200 = PER_200_US * CLK_MHZ;
  localparam int CYC_400 = PER_400_US * CLK_MHZ;
  localparam int TMR_W   = 20;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } seq_state_t;
endpackage
`default_nettype wire

// ### conv_rate_timer.sv
`default_nettype none
module conv_rate_timer
  import cap_conv_pkg::*;
#(
  parameter int CYC_LO  = CYC_100,
  parameter int CYC_MID = CYC_200,
  parameter int CYC_HI  = CYC_400
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       clear_i,
  input  wire logic [1:0] rate_i,
  // Sample tick
  output logic            tick_o
);
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;
  logic [TMR_W-1:0] period;
  logic [1:0]       rate_q;
  logic             next_tick;

  always_comb begin
    unique case (rate_i)
      RATE_100: period = TMR_W'(CYC_LO - 1);
      RATE_200: period = TMR_W'(CYC_MID - 1);
      default:  period = TMR_W'(CYC_HI - 1);
    endcase
    next_cnt  = cnt + 1'b1;
    next_tick = 1'b0;
    // Restart on a new rate so the first period is whole
    if (clear_i || rate_i != rate_q || rate_i == RATE_RSVD) begin
      next_cnt = '0;
    end else if (cnt >= period) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      rate_q <= RATE_RST;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      rate_q <= rate_i;
      tick_o <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ### trim_apply.sv
`default_nettype none
module trim_apply
  import cap_conv_pkg::*;
(
  // Raw result and trims
  input  wire logic [23:0] raw_i,
  input  wire logic [15:0] off_i,
  input  wire logic [15:0] gain_i,
  // Corrected result
  output logic      [23:0] cal_o
);
  logic signed [24:0] sum;
  logic signed [16:0] gain_s;
  logic signed [41:0] prod;
  logic signed [27:0] scaled;

  always_comb begin
    // Offset is 5.11 pF, result is scaled by 2^19 [RULE8] [RULE9] [RULE18]
    sum    = $signed({raw_i[23], raw_i})
           + $signed({off_i[15], off_i, 8'h00});
    // Unsigned 2.14 gain [RULE12] [RULE13]
    gain_s = $signed({1'b0, gain_i});
    prod   = sum * gain_s;
    scaled = prod[41:GAIN_FRAC];
    // Saturate rather than wrap on extreme trims [RULE7] [RULE11]
    if (scaled > 28'sh07FFFFF) begin
      cal_o = 24'h7FFFFF;
    end else if (scaled < -28'sh0800000) begin
      cal_o = 24'h800000;
    end else begin
      cal_o = scaled[23:0];
    end
  end
endmodule
`default_nettype wire

// ### cap_converter_control_regs.sv
`default_nettype none
// Function
// RULE1: Top config bit one starts full reset
// RULE2: Reset bit reads zero after reset completes
// RULE3: Reserved config bits read zero, ignore writes
// RULE4: Repeat bit re-runs every enabled measurement
// RULE5: Four start bits enable and trigger measurements
// RULE6: Four read-only done flags per measurement
// RULE7: Per-channel fine offset added to capacitance
// RULE8: Offset bits 15..11 signed integer picofarads
// RULE9: Offset bits 10..0 are fraction
// RULE10: Fine offset combines with coarse offset array
// RULE11: Per-channel 16-bit gain factor below four
// RULE12: Gain bits 15..14 unsigned integer part
// RULE13: Gain bits 13..0 fraction, word over 2^14
// RULE14: Read-only maker identity at 0xFE
// RULE15: Read-only part identity at 0xFF
// RULE16: Rate codes 01,10,11 give 100,200,400 S/s
// RULE17: Pointer resets zero, set by every write
// RULE18: Results 24-bit scaled by 2^19 plus coarse
module cap_converter_control_regs
  import cap_conv_pkg::*;
#(
  parameter int          RATE_CYC_100 = CYC_100,
  parameter int          RATE_CYC_200 = CYC_200,
  parameter int          RATE_CYC_400 = CYC_400,
  // Arbitrary identity values
  parameter logic [15:0] MAKER_ID     = MAKER_ID_DEF,
  parameter logic [15:0] PART_ID      = PART_ID_DEF
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Register access behind the serial front end
  input  wire logic        ptr_wr_i,
  input  wire logic [7:0]  ptr_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        rd_i,
  output logic      [15:0] rd_data_o,
  output logic             rd_valid_o,
  // Analog front end
  output logic             fe_start_o,
  output logic      [1:0]  fe_chan_o,
  output logic      [1:0]  rate_sel_o,
  input  wire logic        fe_done_i,
  input  wire logic [23:0] fe_data_i,
  // Corrected results
  output logic             meas_valid_o,
  output logic      [1:0]  meas_idx_o,
  output logic      [23:0] meas_data_o,
  // Status
  output logic             soft_reset_o
);
  localparam int SRST_D = SRST_CYC + 1;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0]        ptr, next_ptr;
  logic [15:0]       rd_data, next_rd_data;
  logic              rd_valid, next_rd_valid;
  logic              srst_q;
  logic [SRST_W-1:0] srst_cnt, next_srst_cnt;
  logic [1:0]        rate, next_rate;
  logic              rpt, next_rpt;
  logic [NUM_CH-1:0] start, next_start;
  logic [NUM_CH-1:0] done, next_done;
  logic [NUM_CH-1:0] pending, next_pending;
  logic [15:0]       off_trim [NUM_CH];
  logic [15:0]       next_off [NUM_CH];
  logic [15:0]       gain_trim [NUM_CH];
  logic [15:0]       next_gain [NUM_CH];
  seq_state_t        state, next_state;
  logic [1:0]        cur, next_cur;
  logic              fe_start, next_fe_start;
  logic              meas_valid, next_meas_valid;
  logic [1:0]        meas_idx, next_meas_idx;
  logic [23:0]       meas_data, next_meas_data;

  logic              busy;
  logic              tick;
  logic              wr_ok;
  logic [15:0]       conf_word;
  logic [7:0]        off_rel;
  logic [7:0]        gain_rel;
  logic [1:0]        sel;
  logic [NUM_CH-1:0] done_set;
  logic [NUM_CH-1:0] done_clr;
  logic [23:0]       cal_data;

  assign busy  = srst_cnt != '0;
  assign wr_ok = wr_i && !busy;
  assign off_rel  = ptr - ADDR_OFF_FIRST;
  assign gain_rel = ptr - ADDR_GAIN_FIRST;

  assign rd_data_o    = rd_data;
  assign rd_valid_o   = rd_valid;
  assign fe_start_o   = fe_start;
  assign fe_chan_o    = cur;
  assign rate_sel_o   = rate;
  assign meas_valid_o = meas_valid;
  assign meas_idx_o   = meas_idx;
  assign meas_data_o  = meas_data;
  assign soft_reset_o = srst_q;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  conv_rate_timer #(
    .CYC_LO  (RATE_CYC_100),
    .CYC_MID (RATE_CYC_200),
    .CYC_HI  (RATE_CYC_400)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (busy),
    .rate_i    (rate),
    .tick_o    (tick)
  );

  // Raw result assumed already carries the coarse array term [RULE10]
  trim_apply u_trim (
    .raw_i  (fe_data_i),
    .off_i  (off_trim[cur]),
    .gain_i (gain_trim[cur]),
    .cal_o  (cal_data)
  );

  // ----------------------------------------
  // Configuration word and read decode
  // ----------------------------------------
  always_comb begin
    conf_word = 16'h0000;
    conf_word[RST_BIT] = busy;  // [RULE2]
    conf_word[RATE_HI:RATE_LO] = rate;
    conf_word[RPT_BIT] = rpt;
    for (int i = 0; i < NUM_CH; i++) begin
      conf_word[START_HI-i] = start[i];
      conf_word[DONE_HI-i]  = done[i];  // [RULE6]
    end
  end

  always_comb begin
    next_ptr      = ptr;
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    if (ptr_wr_i) begin
      next_ptr = ptr_i;  // [RULE17]
    end
    if (rd_i) begin
      next_rd_valid = 1'b1;
      if (ptr == ADDR_CONF) begin
        next_rd_data = conf_word;  // [RULE3]
      end else if (ptr >= ADDR_OFF_FIRST && ptr <= ADDR_OFF_LAST) begin
        next_rd_data = off_trim[off_rel[1:0]];
      end else if (ptr >= ADDR_GAIN_FIRST && ptr <= ADDR_GAIN_LAST) begin
        next_rd_data = gain_trim[gain_rel[1:0]];
      end else if (ptr == ADDR_MAKER) begin
        next_rd_data = MAKER_ID;  // [RULE14]
      end else if (ptr == ADDR_PART) begin
        next_rd_data = PART_ID;  // [RULE15]
      end else begin
        next_rd_data = 16'h0000;
      end
    end
  end

  // Pointer is kept over a soft reset so polling needs no rewrite
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ptr      <= PTR_RST;
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
      srst_cnt <= '0;
      srst_q   <= 1'b0;
    end else begin
      ptr      <= next_ptr;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
      srst_cnt <= next_srst_cnt;
      // Registered copy of busy for the status pin
      srst_q   <= next_srst_cnt != '0;
    end
  end

  // ----------------------------------------
  // Control, trims and sequencer
  // ----------------------------------------
  always_comb begin
    sel = 2'd0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        sel = 2'(i);
      end
    end
  end

  always_comb begin
    next_srst_cnt   = busy ? srst_cnt - 1'b1 : srst_cnt;
    next_rate       = rate;
    next_rpt        = rpt;
    next_start      = start;
    next_pending    = pending;
    next_off        = off_trim;
    next_gain       = gain_trim;
    next_state      = state;
    next_cur        = cur;
    next_fe_start   = 1'b0;
    next_meas_valid = 1'b0;
    next_meas_idx   = meas_idx;
    next_meas_data  = meas_data;
    done_set        = '0;
    done_clr        = '0;
    unique case (state)
      ST_IDLE: begin
        if (tick && pending != '0) begin
          next_fe_start     = 1'b1;
          next_cur          = sel;
          next_pending[sel] = 1'b0;
          next_state        = ST_CONV;
        end else if (tick && rpt) begin
          next_pending = start;  // [RULE4]
        end
      end
      ST_CONV: begin
        if (fe_done_i) begin
          next_meas_valid = 1'b1;
          next_meas_idx   = cur;
          next_meas_data  = cal_data;
          done_set[cur]   = 1'b1;  // [RULE6]
          next_state      = ST_IDLE;
        end
      end
    endcase
    if (wr_ok && ptr == ADDR_CONF) begin
      if (wr_data_i[RST_BIT]) begin
        next_srst_cnt = SRST_W'(SRST_CYC);  // [RULE1]
      end
      // Unused rate code 00 simply stops sampling [RULE16]
      next_rate = wr_data_i[RATE_HI:RATE_LO];
      next_rpt  = wr_data_i[RPT_BIT];
      for (int i = 0; i < NUM_CH; i++) begin
        next_start[i] = wr_data_i[START_HI-i];  // [RULE5]
      end
      next_pending = next_start;  // [RULE5]
      done_clr     = next_start;
    end
    if (wr_ok && ptr >= ADDR_OFF_FIRST && ptr <= ADDR_OFF_LAST) begin
      next_off[off_rel[1:0]] = wr_data_i;  // [RULE7]
    end
    if (wr_ok && ptr >= ADDR_GAIN_FIRST && ptr <= ADDR_GAIN_LAST) begin
      next_gain[gain_rel[1:0]] = wr_data_i;  // [RULE11]
    end
    // A completion in the clearing cycle is kept
    next_done = (done & ~done_clr) | done_set;
  end

  // Soft reset holds all control state at reset values [RULE1]
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || busy) begin
      rate       <= RATE_RST;
      rpt        <= 1'b0;
      start      <= '0;
      done       <= '0;
      pending    <= '0;
      state      <= ST_IDLE;
      cur        <= 2'd0;
      fe_start   <= 1'b0;
      meas_valid <= 1'b0;
      meas_idx   <= 2'd0;
      meas_data  <= 24'h000000;
      for (int i = 0; i < NUM_CH; i++) begin
        off_trim[i]  <= OFF_RST;
        gain_trim[i] <= GAIN_RST;
      end
    end else begin
      rate       <= next_rate;
      rpt        <= next_rpt;
      start      <= next_start;
      done       <= next_done;
      pending    <= next_pending;
      state      <= next_state;
      cur        <= next_cur;
      fe_start   <= next_fe_start;
      meas_valid <= next_meas_valid;
      meas_idx   <= next_meas_idx;
      meas_data  <= next_meas_data;
      off_trim   <= next_off;
      gain_trim  <= next_gain;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_srst_req;
    wr_i && !busy && ptr == ADDR_CONF && wr_data_i[RST_BIT];
  endsequence

  property p_srst_start;
    s_srst_req |=> busy ##(SRST_D - 2) busy;
  endproperty
  a_srst_start: assert property (p_srst_start) // [RULE1]
    else $error("soft reset not held for its length");

  property p_srst_end;
    s_srst_req |-> ##SRST_D (!conf_word[RST_BIT] && gain_trim[0] == GAIN_RST);
  endproperty
  a_srst_end: assert property (p_srst_end) // [RULE2]
    else $error("reset bit not cleared after soft reset");

  property p_rsvd;
    rd_valid && $past(ptr) == ADDR_CONF |-> (rd_data & RSVD_MASK) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) // [RULE3]
    else $error("reserved config bit read as one");

  property p_rearm;
    state == ST_IDLE && tick && pending == '0 && !wr_i
      |=> pending == ($past(rpt) ? $past(start) : '0);
  endproperty
  a_rearm: assert property (p_rearm) // [RULE4]
    else $error("repeat rearm wrong");

  property p_disable;
    wr_ok && ptr == ADDR_CONF && !wr_data_i[START_HI] |=> !pending[0];
  endproperty
  a_disable: assert property (p_disable) // [RULE5]
    else $error("disabled measurement still pending");

  sequence s_conv_end;
    state == ST_CONV && fe_done_i;
  endsequence

  property p_done;
    s_conv_end |=> meas_valid && done[meas_idx] && state == ST_IDLE;
  endproperty
  a_done: assert property (p_done) // [RULE6]
    else $error("completion flag not set");

  property p_ptr;
    ptr_wr_i |=> ptr == $past(ptr_i);
  endproperty
  a_ptr: assert property (p_ptr) // [RULE17]
    else $error("pointer not updated");

  property p_maker;
    rd_i && ptr == ADDR_MAKER |=> rd_valid && rd_data == MAKER_ID;
  endproperty
  a_maker: assert property (p_maker) // [RULE14]
    else $error("maker identity wrong");

  property p_part;
    rd_i && ptr == ADDR_PART |=> rd_valid && rd_data == PART_ID;
  endproperty
  a_part: assert property (p_part) // [RULE15]
    else $error("part identity wrong");

  property p_rate_rsvd;
    rate == RATE_RSVD |-> ##1 !tick ##1 !tick;
  endproperty
  a_rate_rsvd: assert property (p_rate_rsvd) // [RULE16]
    else $error("sampling on reserved rate code");
endmodule
`default_nettype wire

// ### fe_model.sv
`default_nettype none
module fe_model #(
  parameter int DLY = 3
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Conversion handshake
  input  wire logic        start_i,
  input  wire logic [23:0] raw_i,
  output logic             done_o,
  output logic      [23:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt;
  logic       busy;

  // ----------------------------------------
  // Conversion delay
  // ----------------------------------------
  // Data toggles outside done so a stale word never looks valid
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (!rst_n_i) begin
      busy   <= 1'b0;
      data_o <= 24'h000000;
    end else if (start_i) begin
      busy <= 1'b1;
      cnt  <= 4'(DLY);
    end else if (busy) begin
      if (cnt == 4'h0) begin
        busy   <= 1'b0;
        done_o <= 1'b1;
        data_o <= raw_i;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### cap_converter_control_regs_test.sv
`default_nettype none
module cap_converter_control_regs_test
  import cap_conv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys_i;
  logic        rst_n_i;
  logic        ptr_wr_i;
  logic [7:0]  ptr_i;
  logic        wr_i;
  logic [15:0] wr_data_i;
  logic        rd_i;
  logic [15:0] rd_data_o;
  logic        rd_valid_o;
  logic        fe_start_o;
  logic [1:0]  fe_chan_o;
  logic [1:0]  rate_sel_o;
  logic        fe_done_i;
  logic [23:0] fe_data_i;
  logic        meas_valid_o;
  logic [1:0]  meas_idx_o;
  logic [23:0] meas_data_o;
  logic        soft_reset_o;
  logic [23:0] raw;
  logic [31:0] seed;
  logic [15:0] off_m [4];
  logic [15:0] gain_m [4];
  logic [23:0] rq [$];
  logic [31:0] mq [$];
  logic [31:0] x;
  int          fail_count;
  int          num_checks;

  cap_converter_control_regs #(
    .RATE_CYC_100 (20),
    .RATE_CYC_200 (10),
    .RATE_CYC_400 (5)
  ) uut (.*);

  fe_model fe (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (fe_start_o),
    .raw_i     (raw),
    .done_o    (fe_done_i),
    .data_o    (fe_data_i)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [23:0] calc(logic [23:0] r, logic [15:0] o,
                                       logic [15:0] g);
    longint s;
    s = longint'($signed(r)) + (longint'($signed(o)) <<< 8);
    s = (s * longint'(g)) >>> 14;
    if (s > 64'sh7FFFFF) s = 64'sh7FFFFF;
    if (s < -64'sh800000) s = -64'sh800000;
    return s[23:0];
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Pointer is always written before the data access
  task automatic set_ptr(input logic [7:0] a);
    @(posedge clk_sys_i);
    ptr_wr_i <= 1'b1;
    ptr_i    <= a;
    @(posedge clk_sys_i);
    ptr_wr_i <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    set_ptr(a);
    wr_i      <= 1'b1;
    wr_data_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    set_ptr(a);
    rd_i <= 1'b1;
    rq.push_back({a, e});
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
  endtask

  task automatic end_test(string name);
    for (int i = 0; i < 600 && rq.size() + mq.size() > 0; i++)
      @(posedge clk_sys_i);
    check("pending results", 32'(rq.size() + mq.size()), 32'h0);
    $display("test %s done", name);
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (rd_valid_o === 1'b1) begin
      if (rq.size() == 0) check("unexpected read", 32'h1, 32'h0);
      else begin
        x = {8'h00, rq.pop_front()};
        check($sformatf("reg %h", x[23:16]), {16'h0000, rd_data_o},
              {16'h0000, x[15:0]});
      end
    end
    if (fe_start_o === 1'b1) begin
      if (mq.size() == 0) check("unexpected start", 32'h1, 32'h0);
      else check("fe_chan_o", 32'(fe_chan_o),
                 32'(mq[0][25:24]));
    end
    if (meas_valid_o === 1'b1) begin
      if (mq.size() == 0) check("unexpected result", 32'h1, 32'h0);
      else check("result", {6'h00, meas_idx_o, meas_data_o},
                 mq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    ptr_wr_i = 1'b0;
    ptr_i = 8'h00;
    wr_i = 1'b0;
    wr_data_i = 16'h0000;
    rd_i = 1'b0;
    raw = 24'h000000;
    seed = 32'h0000482F;
    fail_count = 0;
    num_checks = 0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;

    rd_reg(ADDR_CONF, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'(ADDR_OFF_FIRST + i), OFF_RST);
      rd_reg(8'(ADDR_GAIN_FIRST + i), GAIN_RST);
    end
    rd_reg(ADDR_MAKER, MAKER_ID_DEF);
    rd_reg(ADDR_PART, PART_ID_DEF);
    end_test("reset values");

    // Positive offsets keep the expected sum clear of rounding doubts
    for (int i = 0; i < 4; i++) begin
      off_m[i]  = 16'(rnd()) & 16'h3FFF;
      gain_m[i] = 16'(rnd());
      wr_reg(8'(ADDR_OFF_FIRST + i), off_m[i]);
      wr_reg(8'(ADDR_GAIN_FIRST + i), gain_m[i]);
    end
    wr_reg(ADDR_MAKER, 16'(rnd()));
    wr_reg(ADDR_PART, 16'(rnd()));
    wr_reg(8'h15, 16'hFFFF);
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'(ADDR_OFF_FIRST + i), off_m[i]);
      rd_reg(8'(ADDR_GAIN_FIRST + i), gain_m[i]);
    end
    rd_reg(ADDR_MAKER, MAKER_ID_DEF);
    rd_reg(ADDR_PART, PART_ID_DEF);
    rd_reg(8'h15, 16'h0000);
    end_test("trims and identity");

    wr_reg(ADDR_CONF, 16'h720F);
    rd_reg(ADDR_CONF, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_CONF, {4'h0, 2'(c), 10'h000});
      rd_reg(ADDR_CONF, {4'h0, 2'(c), 10'h000});
      check("rate_sel_o", 32'(rate_sel_o), 32'(c));
    end
    end_test("config fields");

    raw = 24'(rnd()) & 24'h0FFFFF;
    mq.push_back({6'h00, 2'h1, calc(raw, off_m[1], gain_m[1])});
    wr_reg(ADDR_CONF, 16'h0440);
    end_test("single measurement");
    // No second result may appear without repeat
    repeat (60) @(posedge clk_sys_i);
    rd_reg(ADDR_CONF, 16'h0444);
    // Done flags are read-only: writing ones must not clear them
    wr_reg(ADDR_CONF, 16'h0404);
    rd_reg(ADDR_CONF, 16'h0404);
    end_test("done flags");

    raw = 24'(rnd()) & 24'h0FFFFF;
    for (int k = 0; k < 8; k++)
      mq.push_back({6'h00, 2'(k), calc(raw, off_m[k%4], gain_m[k%4])});
    wr_reg(ADDR_CONF, 16'h05F0);
    end_test("repeat");
    wr_reg(ADDR_CONF, 16'h0000);
    repeat (60) @(posedge clk_sys_i);

    wr_reg(ADDR_CONF, 16'h8000);
    @(posedge clk_sys_i);
    check("soft_reset_o", 32'(soft_reset_o), 32'h1);
    rd_reg(ADDR_CONF, 16'h8000);
    wr_reg(ADDR_OFF_FIRST, 16'h1234);
    for (int i = 0; i < 80 && soft_reset_o !== 1'b0; i++)
      @(posedge clk_sys_i);
    check("soft_reset_o", 32'(soft_reset_o), 32'h0);
    rd_reg(ADDR_CONF, 16'h0000);
    rd_reg(ADDR_OFF_FIRST, OFF_RST);
    rd_reg(ADDR_GAIN_LAST, GAIN_RST);
    end_test("soft reset");
    finish_test();
  end
endmodule
`default_nettype wire
